// file: hw/pmc_pkg.sv
/*
  shared constants and carrier types of the power mode controller:
  apb register offsets, field layouts, reset values, mode codes and wake timing.
  assumes a 20 MHz system clock and 32-bit apb data.
*/
package pmc_pkg;

  // clock and wake timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int IDLE_WAKE_NS = 14000;
  localparam int STBY_WAKE_NS = 151000;
  localparam int RST_WAKE_NS = 1015000;
  localparam int IDLE_WAKE_CYC = (IDLE_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STBY_WAKE_CYC = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_WAKE_CYC = (RST_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CNT_W = 16;

  // sizes
  localparam int NUM_GPIO = 32;
  localparam int NUM_SRAM_BLK = 4;
  localparam int NUM_IRQ = 3;

  // register byte offsets
  localparam logic [7:0] OFS_MODE_REQ = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RST_CAUSE = 8'h08;
  localparam logic [7:0] OFS_SRAM_RET = 8'h0c;
  localparam logic [7:0] OFS_CACHE_CTRL = 8'h10;
  localparam logic [7:0] OFS_WAKE_PIN_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h1c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h20;

  // mode request codes
  localparam logic [1:0] REQ_IDLE = 2'h1;
  localparam logic [1:0] REQ_STANDBY = 2'h2;
  localparam logic [1:0] REQ_SHUTDOWN = 2'h3;

  // reset cause bits
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_RST_PIN = 1;
  localparam int CAUSE_PIN_WAKE = 2;
  localparam logic [2:0] RST_CAUSE_RESET = 3'h1;

  // interrupt bits
  localparam int IRQ_WAKE_DONE = 0;
  localparam int IRQ_REQ_REFUSED = 1;
  localparam int IRQ_MODE_ENTERED = 2;

  // reset values
  localparam logic [3:0] SRAM_RET_RESET = 4'hf;
  localparam logic CACHE_EN_RESET = 1'b1;
  localparam logic [31:0] WAKE_PIN_EN_RESET = 32'h0000_0000;

  // sequencer states
  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_IDLE,
    ST_STANDBY,
    ST_SHUTDOWN,
    ST_RST_HOLD,
    ST_WAKE
  } pmc_state_e;

  // per-domain power and clock gates
  typedef struct packed {
    logic cpu_clk_en;
    logic mem_clk_en;
    logic flash_pwr;
    logic sram_pwr;
    logic radio_pwr;
    logic periph_pwr;
    logic supply_on;
    logic supply_duty;
    logic hf_clk_en;
    logic lf_clk_en;
    logic always_on_domain_pwr;
    logic brownout_detector_en;
    logic brownout_detector_duty;
    logic por_en;
  } pmc_gate_s;

  localparam pmc_gate_s GATE_RESET = '0;

endpackage

// file: hw/pmc_top.sv
/*
  power mode controller: sequences active, idle, standby, shutdown and
  reset-pin hold, drives the domain gates, latches i/o, runs wake timing,
  keeps reset cause, sram retention and cache-as-ram control, apb slave.
  assumes wake pins, rtc event and reset pin come from other domains;
  irq_pending_in and gpio_drive_in come from logic on clk_in.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
// How it works
// R01 - active: cpu, memories, radio, peripherals and any clock source enabled
// R02 - idle: cpu and memory clocks stopped, peripherals and radio stay available
// R03 - idle returns to active on any interrupt event
// R04 - standby: only always-on domain powered, supply duty cycled, partial retention
// R05 - standby left only on external wake or rtc event
// R06 - standby wake resumes cpu without reset, retained peripherals keep settings
// R07 - all gpio held latched throughout standby
// R08 - shutdown powers everything off and latches pre-entry i/o values
// R09 - shutdown keeps only latched i/o; sram and registers are lost
// R10 - level change on enabled shutdown wake pin wakes with a reset
// R11 - reset cause register tells pin wake, reset pin and power-on reset apart
// R12 - reset pin wakes from any mode; holding it turns everything off
// R13 - wake latency 14 us idle, 151 us standby, 1015 us shutdown or reset
// R14 - brownout detector active in active/idle, duty cycled standby, off shutdown
// R15 - power-on reset circuit active in all four software modes
// R16 - four sram blocks, each with its own standby retention enable
// R17 - with flash cache off, the cache memory serves as general ram
// R18 - low-power modes only on software request; requests ignored during wake
`timescale 1ns/1ps
module pmc_top #(
  parameter int RST_WAKE_CYCLES = pmc_pkg::RST_WAKE_CYC
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // wake sources
  input wire logic irq_pending_in,
  input wire logic rtc_event_in,
  input wire logic ext_wake_in,
  input wire logic reset_pin_n_in,
  input wire logic [pmc_pkg::NUM_GPIO-1:0] gpio_pin_in,
  // i/o latch
  input wire logic [pmc_pkg::NUM_GPIO-1:0] gpio_drive_in,
  output logic io_latch_out,
  output logic [pmc_pkg::NUM_GPIO-1:0] io_latch_val_out,
  // domain control
  output pmc_pkg::pmc_gate_s gates_out,
  output logic [pmc_pkg::NUM_SRAM_BLK-1:0] sram_ret_out,
  output logic cache_as_ram_out,
  output logic sys_rst_out,
  output logic irq_out
);
  import pmc_pkg::*;

  pmc_state_e state_q;
  pmc_state_e from_q;
  logic [WAKE_CNT_W-1:0] wake_cnt_q;
  logic [2:0] rst_cause_q;
  logic [NUM_SRAM_BLK-1:0] sram_ret_q;
  logic cache_en_q;
  logic [NUM_GPIO-1:0] wake_pin_en_q;
  logic [NUM_IRQ-1:0] irq_status_q;
  logic [NUM_IRQ-1:0] irq_enable_q;
  logic [NUM_IRQ-1:0] irq_set;
  logic [NUM_IRQ-1:0] irq_clr;
  logic rtc_s1_q, rtc_s2_q, rtc_s3_q;
  logic ext_s1_q, ext_s2_q;
  logic rpin_s1_q, rpin_s2_q;
  logic [NUM_GPIO-1:0] gpio_s1_q, gpio_s2_q, gpio_s3_q;
  logic apb_acc, apb_wr, apb_rd;
  logic rtc_evt, pin_change, rst_held;
  logic req_write, req_ok;
  logic [1:0] req_code;
  logic wake_done, rst_wake;
  pmc_gate_s gate_d;

  // two-flop synchronisers for signals from other domains
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rtc_s1_q <= 1'b0;
      rtc_s2_q <= 1'b0;
      rtc_s3_q <= 1'b0;
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      rpin_s1_q <= 1'b1;
      rpin_s2_q <= 1'b1;
      gpio_s1_q <= '0;
      gpio_s2_q <= '0;
      gpio_s3_q <= '0;
    end else if (clk_en_in) begin
      rtc_s1_q <= rtc_event_in;
      rtc_s2_q <= rtc_s1_q;
      rtc_s3_q <= rtc_s2_q;
      ext_s1_q <= ext_wake_in;
      ext_s2_q <= ext_s1_q;
      rpin_s1_q <= reset_pin_n_in;
      rpin_s2_q <= rpin_s1_q;
      gpio_s1_q <= gpio_pin_in;
      gpio_s2_q <= gpio_s1_q;
      gpio_s3_q <= gpio_s2_q;
    end
  end

  // event decode from synchronised inputs
  assign rtc_evt = rtc_s2_q & ~rtc_s3_q;
  assign pin_change = |((gpio_s2_q ^ gpio_s3_q) & wake_pin_en_q); // R10
  assign rst_held = ~rpin_s2_q; // R12

  // apb access qualification; answer comes one cycle into the access phase
  assign apb_acc = psel_in & penable_in & pready_out;
  assign apb_wr = apb_acc & pwrite_in;
  assign apb_rd = psel_in & penable_in & ~pready_out & ~pwrite_in;
  assign req_write = apb_wr & (paddr_in == OFS_MODE_REQ);
  assign req_code = pwdata_in[1:0];
  assign req_ok = req_write & (req_code != 2'h0) & (state_q == ST_ACTIVE); // R18
  assign wake_done = (state_q == ST_WAKE) & (wake_cnt_q == '0);
  assign rst_wake = (state_q == ST_WAKE) & ((from_q == ST_SHUTDOWN) | (from_q == ST_RST_HOLD)); // R10 R12

  // mode sequencer
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_ACTIVE;
      from_q <= ST_ACTIVE;
      wake_cnt_q <= '0;
    end else if (clk_en_in) begin
      if (rst_held) begin
        state_q <= ST_RST_HOLD; // R12
        from_q <= ST_RST_HOLD;
      end else begin
        case (state_q)
          ST_ACTIVE: begin
            if (req_ok) begin // R18
              case (req_code)
                REQ_IDLE: state_q <= ST_IDLE; // R02
                REQ_STANDBY: state_q <= ST_STANDBY; // R04
                default: state_q <= ST_SHUTDOWN; // R08
              endcase
            end
          end
          ST_IDLE: begin
            if (irq_pending_in || rtc_evt || ext_s2_q) begin // R03
              state_q <= ST_WAKE;
              from_q <= ST_IDLE;
              wake_cnt_q <= WAKE_CNT_W'(IDLE_WAKE_CYC - 1); // R13
            end
          end
          ST_STANDBY: begin
            if (rtc_evt || ext_s2_q) begin // R05
              state_q <= ST_WAKE;
              from_q <= ST_STANDBY;
              wake_cnt_q <= WAKE_CNT_W'(STBY_WAKE_CYC - 1); // R13
            end
          end
          ST_SHUTDOWN: begin
            if (pin_change || ext_s2_q) begin // R10
              state_q <= ST_WAKE;
              from_q <= ST_SHUTDOWN;
              wake_cnt_q <= WAKE_CNT_W'(RST_WAKE_CYCLES - 1); // R13
            end
          end
          ST_RST_HOLD: begin
            state_q <= ST_WAKE; // R12
            wake_cnt_q <= WAKE_CNT_W'(RST_WAKE_CYCLES - 1); // R13
          end
          ST_WAKE: begin
            if (wake_cnt_q == '0) begin
              state_q <= ST_ACTIVE;
            end else begin
              wake_cnt_q <= wake_cnt_q - 1'b1;
            end
          end
          default: state_q <= ST_ACTIVE;
        endcase
      end
    end
  end

  // gate table per mode; wake uses the idle set, cpu and memory clocks off until it restarts
  always_comb begin
    gate_d = GATE_RESET;
    gate_d.por_en = 1'b1; // R15
    case (state_q)
      ST_ACTIVE: begin
        gate_d.cpu_clk_en = 1'b1; // R01
        gate_d.mem_clk_en = 1'b1;
        gate_d.flash_pwr = 1'b1;
        gate_d.sram_pwr = 1'b1;
        gate_d.radio_pwr = 1'b1;
        gate_d.periph_pwr = 1'b1;
        gate_d.supply_on = 1'b1;
        gate_d.hf_clk_en = 1'b1;
        gate_d.lf_clk_en = 1'b1;
        gate_d.always_on_domain_pwr = 1'b1;
        gate_d.brownout_detector_en = 1'b1; // R14
      end
      ST_IDLE, ST_WAKE: begin
        gate_d.flash_pwr = 1'b1; // R02
        gate_d.sram_pwr = 1'b1;
        gate_d.radio_pwr = 1'b1;
        gate_d.periph_pwr = 1'b1;
        gate_d.supply_on = 1'b1;
        gate_d.hf_clk_en = 1'b1;
        gate_d.lf_clk_en = 1'b1;
        gate_d.always_on_domain_pwr = 1'b1;
        gate_d.brownout_detector_en = 1'b1; // R14
      end
      ST_STANDBY: begin
        gate_d.sram_pwr = 1'b1; // R04
        gate_d.supply_duty = 1'b1;
        gate_d.lf_clk_en = 1'b1;
        gate_d.always_on_domain_pwr = 1'b1;
        gate_d.brownout_detector_en = 1'b1; // R14
        gate_d.brownout_detector_duty = 1'b1;
      end
      ST_SHUTDOWN: gate_d.por_en = 1'b1; // R08 R09 R14
      ST_RST_HOLD: gate_d.por_en = 1'b0; // R12
      default: gate_d = GATE_RESET;
    endcase
  end

  // registered domain gates
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gates_out <= GATE_RESET;
    end else if (clk_en_in) begin
      gates_out <= gate_d;
    end
  end

  // system reset during hold, shutdown and reset-type wakes; standby wake resumes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sys_rst_out <= 1'b1;
    end else if (clk_en_in) begin
      sys_rst_out <= (state_q == ST_RST_HOLD) || (state_q == ST_SHUTDOWN) || rst_wake; // R06 R09 R10 R12
    end
  end

  // i/o latch captured on entry to standby or shutdown, held until active
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      io_latch_out <= 1'b0;
      io_latch_val_out <= '0;
    end else if (clk_en_in) begin
      if (req_ok && (req_code == REQ_STANDBY || req_code == REQ_SHUTDOWN) && !rst_held) begin
        io_latch_out <= 1'b1; // R07 R08
        io_latch_val_out <= gpio_drive_in;
      end else if (state_q == ST_ACTIVE) begin
        io_latch_out <= 1'b0;
      end
    end
  end

  // reset cause: power-on at reset, reset pin or wake-pin reset later
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_cause_q <= RST_CAUSE_RESET; // R11
    end else if (clk_en_in) begin
      if (rst_held) begin
        rst_cause_q <= 3'h1 << CAUSE_RST_PIN; // R11
      end else if (state_q == ST_SHUTDOWN && (pin_change || ext_s2_q)) begin
        rst_cause_q <= 3'h1 << CAUSE_PIN_WAKE; // R10 R11
      end
    end
  end

  // software configuration registers; kept through shutdown for the wake pins, lost on reset-type wakes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sram_ret_q <= SRAM_RET_RESET;
      cache_en_q <= CACHE_EN_RESET;
      wake_pin_en_q <= WAKE_PIN_EN_RESET;
      irq_enable_q <= '0;
    end else if (clk_en_in) begin
      if (apb_wr && paddr_in == OFS_SRAM_RET) begin
        sram_ret_q <= pwdata_in[NUM_SRAM_BLK-1:0]; // R16
      end
      if (apb_wr && paddr_in == OFS_CACHE_CTRL) begin
        cache_en_q <= pwdata_in[0]; // R17
      end
      if (apb_wr && paddr_in == OFS_WAKE_PIN_EN) begin
        wake_pin_en_q <= pwdata_in; // R10
      end
      if (apb_wr && paddr_in == OFS_IRQ_ENABLE) begin
        irq_enable_q <= pwdata_in[NUM_IRQ-1:0];
      end
      if (state_q == ST_RST_HOLD || rst_wake) begin // R09 R12
        sram_ret_q <= SRAM_RET_RESET;
        cache_en_q <= CACHE_EN_RESET;
        wake_pin_en_q <= WAKE_PIN_EN_RESET;
        irq_enable_q <= '0;
      end
    end
  end

  // retention only matters in standby; cache-as-ram when caching is off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sram_ret_out <= '0;
      cache_as_ram_out <= 1'b0;
    end else if (clk_en_in) begin
      sram_ret_out <= (state_q == ST_STANDBY) ? sram_ret_q : '0; // R16
      cache_as_ram_out <= ~cache_en_q; // R17
    end
  end

  // interrupt events, set wins over clear
  assign irq_set[IRQ_WAKE_DONE] = wake_done;
  assign irq_set[IRQ_REQ_REFUSED] = req_write & ~req_ok;
  assign irq_set[IRQ_MODE_ENTERED] = req_ok;
  assign irq_clr = (apb_wr && paddr_in == OFS_IRQ_CLEAR) ? pwdata_in[NUM_IRQ-1:0] : '0;

  generate
    for (genvar i = 0; i < NUM_IRQ; i++) begin : g_irq
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          irq_status_q[i] <= 1'b0;
        end else if (clk_en_in) begin
          irq_status_q[i] <= irq_set[i] | (irq_status_q[i] & ~irq_clr[i]);
        end
      end
    end
  endgenerate

  // level interrupt output
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      irq_out <= |(irq_status_q & irq_enable_q);
    end
  end

  // apb answer: ready, read data and error one cycle into access phase
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
      prdata_out <= '0;
      pslverr_out <= 1'b0;
    end else if (clk_en_in) begin
      pready_out <= psel_in & penable_in & ~pready_out;
      pslverr_out <= 1'b0;
      prdata_out <= '0;
      if (psel_in && penable_in && !pready_out) begin
        case (paddr_in)
          OFS_MODE_REQ, OFS_IRQ_CLEAR: prdata_out <= '0;
          OFS_STATUS: prdata_out <= {28'h0, state_q == ST_WAKE, 3'(state_q)};
          OFS_RST_CAUSE: prdata_out <= {29'h0, rst_cause_q}; // R11
          OFS_SRAM_RET: prdata_out <= {28'h0, sram_ret_q};
          OFS_CACHE_CTRL: prdata_out <= {31'h0, cache_en_q};
          OFS_WAKE_PIN_EN: prdata_out <= wake_pin_en_q;
          OFS_IRQ_STATUS: prdata_out <= {29'h0, irq_status_q};
          OFS_IRQ_ENABLE: prdata_out <= {29'h0, irq_enable_q};
          default: pslverr_out <= 1'b1;
        endcase
        if (!apb_rd) begin
          prdata_out <= '0;
        end
      end
    end
  end

endmodule

// file: verification/pmc_sva.sv
/*
  concurrent checks on the ports of the power mode controller.
  assumes one clock, clk_in, and the async active-low reset rst_n_in.
*/
`timescale 1ns/1ps
module pmc_sva import pmc_pkg::*; #(
  parameter int RST_WAKE_CYCLES = RST_WAKE_CYC
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // watched inputs
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic reset_pin_n_in,
  // watched outputs
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic io_latch_out,
  input wire logic [pmc_pkg::NUM_GPIO-1:0] io_latch_val_out,
  input wire pmc_pkg::pmc_gate_s gates_out,
  input wire logic [pmc_pkg::NUM_SRAM_BLK-1:0] sram_ret_out,
  input wire logic sys_rst_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  // apb answer: one cycle after the access phase starts, one cycle long
  a_ready_timing: assert property (psel_in && penable_in && !pready_out |=> pready_out)
    else $error("pready late");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  a_ready_cause: assert property (pready_out |-> $past(psel_in && penable_in))
    else $error("pready without access");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  // gate sets per mode
  a_cpu_domains: assert property (
    gates_out.cpu_clk_en |-> gates_out.flash_pwr && gates_out.sram_pwr && gates_out.hf_clk_en
      && gates_out.brownout_detector_en && gates_out.por_en && !gates_out.supply_duty)
    else $error("cpu runs without its domains");
  a_standby_gates: assert property (
    gates_out.brownout_detector_duty |-> !gates_out.cpu_clk_en && !gates_out.radio_pwr
      && !gates_out.periph_pwr && !gates_out.hf_clk_en && gates_out.always_on_domain_pwr)
    else $error("standby gate set wrong");
  a_shutdown_gates: assert property (
    gates_out.por_en && !gates_out.always_on_domain_pwr |-> gates_out == 14'h0001 && sys_rst_out)
    else $error("shutdown gate set wrong");
  // latched pins and retention
  a_latch_hold: assert property (io_latch_out ##1 io_latch_out |-> $stable(io_latch_val_out))
    else $error("latched value moved");
  a_ret_latched: assert property (|sram_ret_out |-> io_latch_out)
    else $error("retention outside standby");
  // held reset pin turns the system off
  a_pin_hold: assert property (
    !reset_pin_n_in [*6] |-> sys_rst_out && !gates_out.cpu_clk_en && !gates_out.radio_pwr)
    else $error("reset pin hold ignored");
endmodule

bind pmc_top pmc_sva #(.RST_WAKE_CYCLES(RST_WAKE_CYCLES)) u_sva (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in),
  .reset_pin_n_in(reset_pin_n_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .io_latch_out(io_latch_out), .io_latch_val_out(io_latch_val_out), .gates_out(gates_out),
  .sram_ret_out(sram_ret_out), .sys_rst_out(sys_rst_out));

// file: verification/pmc_wake_src.sv
/*
  wake sources around the controller: interrupt line, rtc event, external wake,
  reset pin and pin levels, each moved on a bench command.
  assumes kick_in and pin_flip_in commands arrive as one-cycle pulses on clk_in; hold_rst_in and cpu_run_in are levels.
*/
`timescale 1ns/1ps
module pmc_wake_src (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // bench commands
  input wire logic [2:0] kick_in,
  input wire logic [31:0] pin_flip_in,
  input wire logic cpu_run_in,
  input wire logic hold_rst_in,
  // wake sources
  output logic irq_pending_out,
  output logic rtc_event_out,
  output logic ext_wake_out,
  output logic reset_pin_n_out,
  output logic [31:0] gpio_pin_out
);
  logic [3:0] rtc_q, ext_q;

  // interrupt stays pending until software runs; events stand four cycles
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_pending_out <= 1'b0;
      rtc_q <= 4'h0;
      ext_q <= 4'h0;
      reset_pin_n_out <= 1'b1;
      gpio_pin_out <= 32'h0;
    end else begin
      irq_pending_out <= kick_in[0] | (irq_pending_out & ~cpu_run_in);
      rtc_q <= {rtc_q[2:0], kick_in[1]};
      ext_q <= {ext_q[2:0], kick_in[2]};
      reset_pin_n_out <= ~hold_rst_in;
      gpio_pin_out <= gpio_pin_out ^ pin_flip_in;
    end
  end
  assign rtc_event_out = |rtc_q;
  assign ext_wake_out = |ext_q;
endmodule

// file: verification/power_mode_controller_tb.sv
/*
  self-checking bench of the power mode controller: apb master, mode walks,
  wake latencies, interrupts, pin latching and reset causes.
  assumes pmc_pkg, pmc_top and pmc_wake_src are compiled first.
*/
`timescale 1ns/1ps
module power_mode_controller_tb;
  import pmc_pkg::*;
  localparam int RWC = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0, er, seen_rst;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, drive = 32'h0, flip = 32'h0, prdata, rd, gpin, lval;
  logic [2:0] kick = 3'h0;
  logic pready, pslverr, irqp, rtc, ext, rpin, latch, car, srst, irq;
  logic [3:0] sram_ret, ret;
  logic [15:0] seed = 16'ha221;
  pmc_gate_s gates;
  int n_errors = 0;
  int cmp_count = 0;
  int n;

  initial forever #25 clk = ~clk;

  pmc_top #(.RST_WAKE_CYCLES(RWC)) DUT (
    .clk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .irq_pending_in(irqp), .rtc_event_in(rtc),
    .ext_wake_in(ext), .reset_pin_n_in(rpin), .gpio_pin_in(gpin), .gpio_drive_in(drive),
    .io_latch_out(latch), .io_latch_val_out(lval), .gates_out(gates), .sram_ret_out(sram_ret),
    .cache_as_ram_out(car), .sys_rst_out(srst), .irq_out(irq));

  pmc_wake_src u_src (
    .clk_in(clk), .rst_n_in(rst_n), .kick_in(kick), .pin_flip_in(flip),
    .cpu_run_in(gates.cpu_clk_en), .hold_rst_in(hold), .irq_pending_out(irqp),
    .rtc_event_out(rtc), .ext_wake_out(ext), .reset_pin_n_out(rpin), .gpio_pin_out(gpin));

  // pseudo-random values and expected wake counts
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic int lat(input int ns);
    return ns / CLK_PERIOD_NS;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    chk("pready", 32'(pready), 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask
  task automatic poke(input logic [2:0] k);
    @(posedge clk);
    kick <= k;
    @(posedge clk);
    kick <= 3'h0;
  endtask
  // cycles until the cpu clock runs again
  task automatic wait_cpu(output int c);
    c = 0;
    seen_rst = 1'b0;
    do begin
      @(posedge clk);
      c++;
      seen_rst = seen_rst | srst;
    end while (gates.cpu_clk_en !== 1'b1 && c < 30000);
  endtask

  // watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rdc("cause_por", OFS_RST_CAUSE, 32'(RST_CAUSE_RESET));
    rdc("ret_rst", OFS_SRAM_RET, 32'(SRAM_RET_RESET));
    rdc("cache_rst", OFS_CACHE_CTRL, 32'(CACHE_EN_RESET));
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped", 32'(er), 32'h1);
    wr(OFS_CACHE_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    chk("cache_ram", 32'(car), 32'h1);
    wr(OFS_CACHE_CTRL, 32'h1);
    repeat (3) begin
      seed = lfsr(seed);
      wr(OFS_SRAM_RET, {28'h0, seed[3:0]});
      rdc("ret_rb", OFS_SRAM_RET, {28'h0, seed[3:0]});
    end
    // idle entry, refused request, interrupt wake
    wr(OFS_IRQ_ENABLE, 32'h7);
    wr(OFS_MODE_REQ, 32'(REQ_IDLE));
    repeat (3) @(posedge clk);
    chk("idle_cpu", 32'(gates.cpu_clk_en | gates.mem_clk_en), 32'h0);
    chk("idle_periph", 32'(gates.radio_pwr & gates.periph_pwr), 32'h1);
    chk("irq_entry", 32'(irq), 32'h1);
    wr(OFS_MODE_REQ, 32'(REQ_STANDBY));
    rdc("idle_keep", OFS_STATUS, 32'h1);
    poke(3'h1);
    wait_cpu(n);
    chk("idle_lat", 32'(n >= lat(IDLE_WAKE_NS) && n <= lat(IDLE_WAKE_NS) + 8), 32'h1);
    rdc("irq_all", OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_CLEAR, 32'h7);
    wr(OFS_IRQ_ENABLE, 32'h0);
    wr(OFS_MODE_REQ, 32'h0);
    rdc("irq_refused", OFS_IRQ_STATUS, 32'h2);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(OFS_IRQ_CLEAR, 32'h2);
    wr(OFS_IRQ_ENABLE, 32'h7);
    // standby, woken by rtc then by external wake
    for (int s = 1; s < 3; s++) begin
      seed = lfsr(seed);
      drive <= {seed, ~seed};
      ret = seed[7:4] | 4'h1;
      wr(OFS_SRAM_RET, {28'h0, ret});
      wr(OFS_MODE_REQ, 32'(REQ_STANDBY));
      repeat (3) @(posedge clk);
      drive <= ~drive;
      chk("stby_latch", 32'(latch), 32'h1);
      chk("stby_ret", 32'(sram_ret), {28'h0, ret});
      chk("stby_bod", 32'(gates.brownout_detector_duty), 32'h1);
      poke(3'h1);
      repeat (400) @(posedge clk);
      chk("stby_stay", 32'(gates.cpu_clk_en), 32'h0);
      chk("stby_val", lval, {seed, ~seed});
      poke(3'(1 << s));
      wait_cpu(n);
      chk("stby_lat", 32'(n >= lat(STBY_WAKE_NS) && n <= lat(STBY_WAKE_NS) + 8), 32'h1);
      chk("stby_resume", 32'(seen_rst), 32'h0);
      rdc("stby_kept", OFS_SRAM_RET, {28'h0, ret});
      chk("stby_free", 32'(latch), 32'h0);
    end
    // shutdown, disabled pin ignored, enabled pin wakes with a reset
    seed = lfsr(seed);
    drive <= {~seed, seed};
    wr(OFS_WAKE_PIN_EN, 32'h8);
    wr(OFS_MODE_REQ, 32'(REQ_SHUTDOWN));
    repeat (3) @(posedge clk);
    chk("sd_gates", 32'(gates), 32'h1);
    chk("sd_val", lval, {~seed, seed});
    flip <= 32'h4;
    @(posedge clk);
    flip <= 32'h0;
    repeat (50) @(posedge clk);
    chk("sd_stay", 32'(gates), 32'h1);
    flip <= 32'h8;
    @(posedge clk);
    flip <= 32'h0;
    wait_cpu(n);
    chk("sd_lat", 32'(n >= RWC && n <= RWC + 8), 32'h1);
    rdc("sd_cause", OFS_RST_CAUSE, 32'h4);
    rdc("sd_lost", OFS_SRAM_RET, 32'(SRAM_RET_RESET));
    // reset pin held from idle
    wr(OFS_MODE_REQ, 32'(REQ_IDLE));
    hold <= 1'b1;
    repeat (10) @(posedge clk);
    chk("hold_off", 32'(gates.cpu_clk_en | gates.radio_pwr | gates.flash_pwr), 32'h0);
    chk("hold_rst", 32'(srst), 32'h1);
    hold <= 1'b0;
    wait_cpu(n);
    chk("hold_lat", 32'(n >= RWC && n <= RWC + 8), 32'h1);
    rdc("hold_cause", OFS_RST_CAUSE, 32'h2);
    end_sim();
  end
endmodule
